// ---- hdl/ccr_pkg.sv ----
// Package for the charger control and overvoltage flag register bank.
`default_nettype none
package ccr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_ADDR_CHARGE_CONTROL = 8'h2B;
    localparam logic [7:0] CCR_ADDR_OVP_LIVE = 8'h2C;
    localparam logic [7:0] CCR_ADDR_OVP_FLAG_MASK = 8'h2D;
    localparam logic [7:0] CCR_ADDR_FILTER_SEL = 8'h2E;
    localparam logic [7:0] CCR_RESET_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CCR_BIT_TIMEOUT_LSB = 5;
    localparam int CCR_BIT_OVP_DISABLE = 3;
    localparam int CCR_BIT_UCP_RISE = 2;
    localparam int CCR_BIT_SENSE_RES = 1;
    localparam int CCR_BIT_PULLDOWN = 0;
    localparam int CCR_BIT_LIVE = 0;
    localparam int CCR_BIT_FLAG = 4;
    localparam int CCR_BIT_MASK = 0;
    localparam int CCR_BIT_VLOW_SEL = 4;
    localparam int CCR_BIT_ILOW_SEL = 3;

    // ------------------------------------------------------------
    // Timing, 40 MHz clock
    // ------------------------------------------------------------
    localparam int CCR_CLK_HZ = 40_000_000;
    localparam int CCR_PULLDOWN_US = 10;
    localparam int CCR_PULLDOWN_CYC = CCR_PULLDOWN_US * (CCR_CLK_HZ / 1_000_000);
    localparam int CCR_FILT_SHORT_US = 10;
    localparam int CCR_FILT_SHORT_CYC = CCR_FILT_SHORT_US * (CCR_CLK_HZ / 1_000_000);
    localparam int CCR_FILT_VLOW_LONG_MS = 10;
    localparam int CCR_FILT_VLOW_LONG_CYC = CCR_FILT_VLOW_LONG_MS * (CCR_CLK_HZ / 1000);
    localparam int CCR_FILT_ILOW_LONG_MS = 5;
    localparam int CCR_FILT_ILOW_LONG_CYC = CCR_FILT_ILOW_LONG_MS * (CCR_CLK_HZ / 1000);
    localparam int CCR_CNT_W = 20;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CCR_PD_IDLE = 2'b01,
        CCR_PD_PULL = 2'b10
    } ccr_pd_state_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_bus_req_t;

    typedef struct packed {
        logic [2:0] timeout_sel;
        logic out_overvolt_disable;
        logic input_undercurrent_rise_level;
        logic battery_sense_resistor_sel;
        logic out_overvolt_latched;
        logic out_overvolt_irq_mask;
        logic bus_voltage_low_err_filter_sel;
        logic bus_current_low_filter_sel;
        ccr_pd_state_t pd_state;
        logic [CCR_CNT_W-1:0] pd_cnt;
        logic [CCR_CNT_W-1:0] vlow_cnt;
        logic [CCR_CNT_W-1:0] ilow_cnt;
        logic vlow_filt;
        logic ilow_filt;
        logic [1:0] ovp_sync;
        logic [1:0] vlow_sync;
        logic [1:0] ilow_sync;
        logic [1:0] sw_sync;
        logic [7:0] rdata;
    } ccr_state_t;

endpackage : ccr_pkg
`default_nettype wire

// ---- hdl/ccr_regs.sv ----
// Register bank for charger control, overvoltage flag and fault filter selection.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register access port
    input wire ccr_pkg::ccr_bus_req_t bus_req,
    output logic [7:0] rdata,
    // Analog status inputs, asynchronous
    input wire logic ovp_condition,
    input wire logic bus_voltage_low_raw,
    input wire logic bus_current_low_raw,
    input wire logic switching_enabled,
    // Control outputs
    output logic [2:0] soft_start_timeout_sel,
    output logic output_overvoltage_protect,
    output logic input_undercurrent_rise_level,
    output logic battery_sense_resistor_sel,
    output logic adapter_input_pulldown_en,
    output logic bus_voltage_low_error,
    output logic bus_current_low,
    output logic irq
);
    import ccr_pkg::*;

    ccr_state_t st;
    ccr_state_t next_st;
    logic live;
    // Decoded strobes for the two registers whose access has side effects.
    logic wr_ctl;
    logic rd_flag;

    // ------------------------------------------------------------
    // Filter length chooser
    // ------------------------------------------------------------
    // The short count is shared by both filters; only the long counts differ.
    function automatic logic [CCR_CNT_W-1:0] filt_len(input logic sel, input int long_cyc);
        filt_len = sel ? CCR_CNT_W'(long_cyc) : CCR_CNT_W'(CCR_FILT_SHORT_CYC);
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // True when a strobe is up for the given register. The flag read-clear and the pull-down
    // counter hold go through here; the pulse start is decoded in the write case.
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
            input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction

    // Protection is reported only while it is enabled.
    assign live = st.ovp_sync[1] & ~st.out_overvolt_disable;

    // Strobes qualified by the decoded address.
    assign wr_ctl = hit(bus_req.wr_en, bus_req.addr, CCR_ADDR_CHARGE_CONTROL);
    assign rd_flag = hit(bus_req.rd_en, bus_req.addr, CCR_ADDR_OVP_FLAG_MASK);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        // --------------------------------------------------------
        // Synchronisers
        // --------------------------------------------------------
        // Only the second stage of each pair feeds logic; the first may be metastable.
        next_st.ovp_sync = {st.ovp_sync[0], ovp_condition};
        next_st.vlow_sync = {st.vlow_sync[0], bus_voltage_low_raw};
        next_st.ilow_sync = {st.ilow_sync[0], bus_current_low_raw};
        next_st.sw_sync = {st.sw_sync[0], switching_enabled};

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        // Reserved bits are never stored; the live register has no writable bit.
        if (bus_req.wr_en) begin
            case (bus_req.addr)
                CCR_ADDR_CHARGE_CONTROL: begin
                    next_st.timeout_sel = bus_req.wdata[CCR_BIT_TIMEOUT_LSB +: 3];
                    next_st.out_overvolt_disable = bus_req.wdata[CCR_BIT_OVP_DISABLE];
                    if (!st.sw_sync[1]) begin
                        // The switching level comes through a synchroniser, so a write in the
                        // two cycles after switching starts still lands.
                        next_st.input_undercurrent_rise_level = bus_req.wdata[CCR_BIT_UCP_RISE];
                    end
                    next_st.battery_sense_resistor_sel = bus_req.wdata[CCR_BIT_SENSE_RES];
                    if (bus_req.wdata[CCR_BIT_PULLDOWN]) begin
                        next_st.pd_state = CCR_PD_PULL;
                        next_st.pd_cnt = '0;
                    end
                end
                CCR_ADDR_OVP_FLAG_MASK: begin
                    next_st.out_overvolt_irq_mask = bus_req.wdata[CCR_BIT_MASK];
                end
                CCR_ADDR_FILTER_SEL: begin
                    next_st.bus_voltage_low_err_filter_sel = bus_req.wdata[CCR_BIT_VLOW_SEL];
                    next_st.bus_current_low_filter_sel = bus_req.wdata[CCR_BIT_ILOW_SEL];
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------
        // Read data
        // --------------------------------------------------------
        // Read data is registered; the flag value returned is the one before any clear.
        // A read and a write in one cycle return the old contents.
        next_st.rdata = '0;
        if (bus_req.rd_en) begin
            case (bus_req.addr)
                CCR_ADDR_CHARGE_CONTROL: begin
                    next_st.rdata[CCR_BIT_TIMEOUT_LSB +: 3] = st.timeout_sel;
                    next_st.rdata[CCR_BIT_OVP_DISABLE] = st.out_overvolt_disable;
                    next_st.rdata[CCR_BIT_UCP_RISE] = st.input_undercurrent_rise_level;
                    next_st.rdata[CCR_BIT_SENSE_RES] = st.battery_sense_resistor_sel;
                    next_st.rdata[CCR_BIT_PULLDOWN] = (st.pd_state == CCR_PD_PULL);
                end
                CCR_ADDR_OVP_LIVE: begin
                    next_st.rdata[CCR_BIT_LIVE] = live;
                end
                CCR_ADDR_OVP_FLAG_MASK: begin
                    next_st.rdata[CCR_BIT_FLAG] = st.out_overvolt_latched;
                    next_st.rdata[CCR_BIT_MASK] = st.out_overvolt_irq_mask;
                end
                CCR_ADDR_FILTER_SEL: begin
                    next_st.rdata[CCR_BIT_VLOW_SEL] = st.bus_voltage_low_err_filter_sel;
                    next_st.rdata[CCR_BIT_ILOW_SEL] = st.bus_current_low_filter_sel;
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------
        // Overvoltage flag
        // --------------------------------------------------------
        // A read clears the flag only once protection has ended; a live event wins.
        // A read while protection is still active leaves the flag set, so no event is lost.
        if (rd_flag && !live) begin
            next_st.out_overvolt_latched = 1'b0;
        end
        if (live) begin
            next_st.out_overvolt_latched = 1'b1;
        end

        // --------------------------------------------------------
        // Pull-down pulse
        // --------------------------------------------------------
        // Pulse of fixed length; a new write restarts it.
        // Bit 0 reads back as one while the pulse runs, so software can poll for its end.
        case (st.pd_state)
            CCR_PD_IDLE: ;
            CCR_PD_PULL: begin
                if (!(wr_ctl && bus_req.wdata[CCR_BIT_PULLDOWN])) begin
                    if (st.pd_cnt == CCR_CNT_W'(CCR_PULLDOWN_CYC - 1)) begin
                        next_st.pd_state = CCR_PD_IDLE;
                    end else begin
                        next_st.pd_cnt = st.pd_cnt + 1'b1;
                    end
                end
            end
            default: next_st.pd_state = CCR_PD_IDLE;
        endcase

        // --------------------------------------------------------
        // Deglitch filters
        // --------------------------------------------------------
        // Output changes after input has held the new level the full time.
        // A select change takes effect at once; a count already past a shorter length
        // ends the filter on the next edge.
        if (st.vlow_sync[1] == st.vlow_filt) begin
            next_st.vlow_cnt = '0;
        end else if (st.vlow_cnt >= filt_len(st.bus_voltage_low_err_filter_sel,
                CCR_FILT_VLOW_LONG_CYC) - 1'b1) begin
            next_st.vlow_filt = st.vlow_sync[1];
            next_st.vlow_cnt = '0;
        end else begin
            next_st.vlow_cnt = st.vlow_cnt + 1'b1;
        end
        if (st.ilow_sync[1] == st.ilow_filt) begin
            next_st.ilow_cnt = '0;
        end else if (st.ilow_cnt >= filt_len(st.bus_current_low_filter_sel,
                CCR_FILT_ILOW_LONG_CYC) - 1'b1) begin
            next_st.ilow_filt = st.ilow_sync[1];
            next_st.ilow_cnt = '0;
        end else begin
            next_st.ilow_cnt = st.ilow_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st <= '0;
            // All zeros is not a legal one-hot code, so the pull-down state is set apart.
            st.pd_state <= CCR_PD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = st.rdata;
    assign soft_start_timeout_sel = st.timeout_sel;
    // Protection is the inverse of the stored disable bit, so reset leaves it on.
    assign output_overvoltage_protect = ~st.out_overvolt_disable;
    assign input_undercurrent_rise_level = st.input_undercurrent_rise_level;
    assign battery_sense_resistor_sel = st.battery_sense_resistor_sel;
    assign adapter_input_pulldown_en = (st.pd_state == CCR_PD_PULL);
    // Deglitched levels come straight from their flops.
    assign bus_voltage_low_error = st.vlow_filt;
    assign bus_current_low = st.ilow_filt;
    // The request is an AND of two flops, so it cannot glitch during a read.
    assign irq = st.out_overvolt_latched & ~st.out_overvolt_irq_mask;

endmodule // ccr_regs
`default_nettype wire

// ---- verif/ccr_host.sv ----
// Host model issuing single-byte register accesses.
`timescale 1ns/1ps
`default_nettype none
module ccr_host (
    // Clock and register port
    input wire logic sys_clk,
    output var ccr_pkg::ccr_bus_req_t bus_req,
    input wire logic [7:0] rdata
);
    import ccr_pkg::*;
    initial bus_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk) bus_req <= '{1'b1, 1'b0, a, v};
        @(posedge sys_clk) bus_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk) bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk) bus_req <= '0;
        #1 v = rdata;
    endtask
endmodule // ccr_host
`default_nettype wire

// ---- verif/ccr_regs_sva.sv ----
// Port checker for the charger control register bank.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_sva (
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic srst,
    input wire ccr_pkg::ccr_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    // Watched pins
    input wire logic bus_current_low_raw,
    input wire logic switching_enabled,
    input wire logic [2:0] soft_start_timeout_sel,
    input wire logic output_overvoltage_protect,
    input wire logic input_undercurrent_rise_level,
    input wire logic adapter_input_pulldown_en,
    input wire logic bus_current_low
);
    import ccr_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    wire logic [7:0] wd = bus_req.wdata;
    wire logic wr_ctl = bus_req.wr_en && bus_req.addr == CCR_ADDR_CHARGE_CONTROL;
    wire logic rd_live = bus_req.rd_en && bus_req.addr == CCR_ADDR_OVP_LIVE;
    wire logic rd_flag = bus_req.rd_en && bus_req.addr == CCR_ADDR_OVP_FLAG_MASK;
    AST_RD_IDLE: assert property (!bus_req.rd_en |=> rdata == 8'h00)
        else $error("read data not idle");
    AST_RSV_LIVE: assert property (rd_live |=> rdata[7:1] == 7'h00)
        else $error("live reserved bits set");
    AST_RSV_FLAG: assert property (rd_flag |=> {rdata[7:5], rdata[3:1]} == 6'h00)
        else $error("flag reserved bits set");
    AST_TMO_WR: assert property (wr_ctl |=> soft_start_timeout_sel == $past(wd[7:5]))
        else $error("timeout select not written");
    AST_DIS_WR: assert property (wr_ctl |=> output_overvoltage_protect != $past(wd[3]))
        else $error("protect enable wrong");
    AST_PD_HOLD: assert property (wr_ctl && wd[0] |=> adapter_input_pulldown_en[*8])
        else $error("pull-down pulse short");
    // The synchroniser needs the level held before a write can be judged.
    AST_UCP_LOCK: assert property (switching_enabled[*4] ##0 wr_ctl
        |=> $stable(input_undercurrent_rise_level)) else $error("threshold moved while switching");
    AST_ILOW_DG: assert property ($rose(bus_current_low)
        |-> $past(bus_current_low_raw, 3) && $past(bus_current_low_raw, 9))
        else $error("current low not filtered");
    cover property (wr_ctl && wd[0]);
    cover property (rd_flag);
    cover property ($rose(bus_current_low));
endmodule // ccr_regs_sva
bind ccr_regs ccr_regs_sva u_sva (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
    .rdata(rdata), .bus_current_low_raw(bus_current_low_raw),
    .switching_enabled(switching_enabled), .soft_start_timeout_sel(soft_start_timeout_sel),
    .output_overvoltage_protect(output_overvoltage_protect),
    .input_undercurrent_rise_level(input_undercurrent_rise_level),
    .adapter_input_pulldown_en(adapter_input_pulldown_en), .bus_current_low(bus_current_low));
`default_nettype wire

// ---- verif/tb_charger_ctrl_ovp_flag_regs.sv ----
// Self-checking bench for the charger control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_charger_ctrl_ovp_flag_regs;
    import ccr_pkg::*;
    logic sys_clk, srst, ovp, vlow, ilow, sw, prot, ucp, res, pd, verr, ilo, irq;
    logic [2:0] tsel;
    logic [7:0] rdata, d;
    ccr_bus_req_t bus_req;
    int mismatches, checks_done, n;
    ccr_host host (.sys_clk(sys_clk), .bus_req(bus_req), .rdata(rdata));
    ccr_regs DUT (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
        .ovp_condition(ovp), .bus_voltage_low_raw(vlow), .bus_current_low_raw(ilow),
        .switching_enabled(sw), .soft_start_timeout_sel(tsel), .output_overvoltage_protect(prot),
        .input_undercurrent_rise_level(ucp), .battery_sense_resistor_sel(res),
        .adapter_input_pulldown_en(pd), .bus_voltage_low_error(verr), .bus_current_low(ilo),
        .irq(irq));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_ctrl();
        chk("protect", 1, prot);
        for (int a = 'h2B; a < 'h31; a++) rc(8'(a), 8'h00);
        for (int k = 0; k < 8; k++) begin
            host.wr(8'h2B, 8'(k << 5) | 8'h1A);
            chk("timeout", k, tsel);
            chk("protect sense", 1, {prot, res});
            rc(8'h2B, 8'(k << 5) | 8'h0A);
        end
        host.wr(8'h2B, 8'h04);
        chk("protect sense level", 5, {prot, res, ucp});
        $display("control test done");
    endtask
    task automatic t_ucp_pd();
        @(posedge sys_clk) sw <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host.wr(8'h2B, 8'h00);
        chk("level locked", 1, ucp);
        @(posedge sys_clk) sw <= 1'b0;
        repeat (4) @(posedge sys_clk);
        host.wr(8'h2B, 8'h01);
        n = 0;
        repeat (500) @(negedge sys_clk) n += (pd === 1'b1);
        chk("pulse length", CCR_PULLDOWN_CYC, n);
        chk("level free", 0, ucp);
        $display("threshold and pull-down test done");
    endtask
    task automatic ovp_to(input logic v);
        @(posedge sys_clk) ovp <= v;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic t_ovp();
        ovp_to(1'b1);
        rc(8'h2C, 8'h01);
        rc(8'h2D, 8'h10);
        chk("irq", 1, irq);
        ovp_to(1'b0);
        rc(8'h2C, 8'h00);
        host.wr(8'h2D, 8'h01);
        chk("irq masked", 0, irq);
        rc(8'h2D, 8'h11);
        rc(8'h2D, 8'h01);
        host.wr(8'h2B, 8'h08);
        ovp_to(1'b1);
        rc(8'h2C, 8'h00);
        ovp_to(1'b0);
        rc(8'h2D, 8'h01);
        $display("overvoltage test done");
    endtask
    task automatic t_filt();
        @(posedge sys_clk) ilow <= 1'b1;
        vlow <= 1'b1;
        for (n = 0; n < 600 && ilo !== 1'b1; n++) @(negedge sys_clk);
        chk("filter delay", 1, n >= CCR_FILT_SHORT_CYC && n <= CCR_FILT_SHORT_CYC + 4);
        if (n >= 600) wrap_up();
        chk("voltage low", 1, verr);
        host.wr(8'h2E, 8'hFF);
        rc(8'h2E, 8'h18);
        @(posedge sys_clk) ilow <= 1'b0;
        vlow <= 1'b0;
        repeat (600) @(posedge sys_clk);
        chk("long filters", 3, {verr, ilo});
        $display("filter test done");
    endtask
    initial begin
        {srst, ovp, vlow, ilow, sw} = 5'b10000;
        mismatches = 0;
        checks_done = 0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_ctrl();
        t_ucp_pd();
        t_ovp();
        t_filt();
        wrap_up();
    end
endmodule // tb_charger_ctrl_ovp_flag_regs
`default_nettype wire
